// *** inc/sensor_regs_consts.svh ***
// register addresses, field positions, reset values and timing counts
// assumes inclusion by the timer, register bank and test modules
`ifndef SENSOR_REGS_CONSTS_SVH
`define SENSOR_REGS_CONSTS_SVH
`define ADDR_CONC 16'h9c41
`define ADDR_TEMP 16'h9c42
`define ADDR_HI_RELAY 16'h9c43
`define ADDR_WARN_RELAY 16'h9c44
`define ADDR_LO_THR 16'h9c45
`define ADDR_HI_THR 16'h9c46
`define ADDR_CFG_DETAIL 16'h9c47
`define ADDR_FW_UPPER 16'h9c48
`define ADDR_FW_LOWER 16'h9c49
`define ADDR_MAP_VER 16'h9c4a
`define ADDR_FAULT_BITS 16'h9c4b
`define ADDR_FAULT_SUM 16'h9c4c
`define ADDR_HI_UNLATCH 16'h9c4d
`define ADDR_WARN_UNLATCH 16'h9c4e
`define ADDR_SERIAL_UP 16'h9c4f
`define ADDR_SERIAL_LO 16'h9c50
`define ADDR_RUN_UP 16'h9c51
`define ADDR_RUN_LO 16'h9c52
`define ADDR_PEAK 16'h9c53
`define ADDR_RANGE 16'h9c54
`define ADDR_UNITS 16'h9c55
`define ADDR_STATE 16'h9c57
`define ADDR_MULT 16'h9c58
`define ADDR_CAL_REF 16'h9c59
`define ADDR_CAL_DUE 16'h9c5a
`define ADDR_LOWEST 16'h9c41
`define ST_RUN_BIT 0
`define ST_ALARM_BIT 1
`define ST_WARM_BIT 2
`define ST_TROUBLE_BIT 3
`define ST_CAL_BIT 4
`define ST_CAL_PASS_BIT 5
`define ST_CAL_FAIL_BIT 6
`define CAL_DUE_LONG 16'h016d
`define CAL_DUE_SHORT 16'h00b4
`define RST_LO_THR 16'h0014
`define RST_HI_THR 16'h003c
`define RST_RANGE 16'h0064
`define RST_UNITS 16'h0001
`define RST_CAL_REF 16'h0032
`define SECOND_S 1
`define CLK_HZ 50000000
`define SECOND_CYCLES (`SECOND_S * `CLK_HZ)
`endif

// *** inc/sensor_regs_pkg.sv ***
// types shared by the register bank
// assumes the consts header sits in the include path
package sensor_regs_pkg;
   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_DECODE,
      ACC_ANSWER
   } access_state_t;
   typedef logic [15:0] word_t;
endpackage

// *** rtl/operating_timer.sv ***
// one-second tick and 32-bit run time counter
// assumes a 50 MHz clock
`include "sensor_regs_consts.svh"
module operating_timer
   import sensor_regs_pkg::*;
#(
   parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
)
(
   input wire logic clock,
   input wire logic rst_n,
   output logic [31:0] seconds
);
   logic [25:0] div_r;
   logic [25:0] div_nxt;
   logic [31:0] sec_r;
   logic [31:0] sec_nxt;
   logic tick;

   always_comb
   begin
      tick = (div_r == 26'(SECOND_CYCLES - 1));
      div_nxt = tick ? 26'h0 : div_r + 26'h1;
      sec_nxt = tick ? sec_r + 32'h1 : sec_r;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_r <= 26'h0;
         sec_r <= 32'h0;
      end
      else
      begin
         div_r <= div_nxt;
         sec_r <= sec_nxt;
      end
   end

   assign seconds = sec_r;

   run_steps_a: assert property (@(posedge clock) disable iff (!rst_n)
      tick |=> sec_r == $past(sec_r) + 32'h1)
      else $error("run time did not advance on tick");
endmodule

// *** rtl/sensor_register_bank.sv ***
// register bank of a gas sensor module, served by read and write commands
// assumes the command decoder hands over address and data as one-cycle
// strobes and the measurement core drives the live inputs on this clock
`include "sensor_regs_consts.svh"
module sensor_register_bank
   import sensor_regs_pkg::*;
#(
   parameter logic [15:0] CFG_DETAIL = 16'h0001, // arbitrary
   parameter logic [15:0] FW_UPPER = 16'h0064, // arbitrary
   parameter logic [15:0] FW_LOWER = 16'h0041, // arbitrary
   parameter logic [15:0] MAP_VER = 16'h0001, // arbitrary
   parameter logic [15:0] PRODUCT_CODE = 16'h1234, // arbitrary
   parameter logic [23:0] SERIAL_ID = 24'h00abcd, // arbitrary
   parameter logic [15:0] MULTIPLIER = 16'h000a,
   parameter logic LONG_CAL_INTERVAL = 1'b1,
   parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_data,
   output logic resp_valid,
   output logic [15:0] resp_data,
   input wire logic [15:0] gas_level,
   input wire logic [15:0] temp_tenths,
   input wire logic [15:0] fault_bits,
   input wire logic warming,
   input wire logic cal_active,
   input wire logic cal_pass,
   input wire logic cal_fail,
   input wire logic day_tick,
   output logic high_alarm_relay,
   output logic warning_relay
);
   access_state_t st_r;
   access_state_t st_nxt;
   logic wr_r;
   logic wr_nxt;
   logic [15:0] addr_r;
   logic [15:0] addr_nxt;
   logic [15:0] data_r;
   logic [15:0] data_nxt;
   logic resp_valid_r;
   logic resp_valid_nxt;
   logic [15:0] resp_r;
   logic [15:0] resp_nxt;
   logic hi_latch_r;
   logic hi_latch_nxt;
   logic warn_latch_r;
   logic warn_latch_nxt;
   logic [15:0] lo_thr_r;
   logic [15:0] lo_thr_nxt;
   logic [15:0] hi_thr_r;
   logic [15:0] hi_thr_nxt;
   logic [15:0] range_r;
   logic [15:0] range_nxt;
   logic [15:0] units_r;
   logic [15:0] units_nxt;
   logic [15:0] cal_ref_r;
   logic [15:0] cal_ref_nxt;
   logic [15:0] cal_due_r;
   logic [15:0] cal_due_nxt;
   logic [15:0] cal_cnt_r;
   logic [15:0] cal_cnt_nxt;
   logic [15:0] peak_r;
   logic [15:0] peak_nxt;
   logic pass_seen_r;
   logic pass_seen_nxt;
   logic [31:0] run_seconds;
   logic [15:0] conc;
   logic hi_now;
   logic warn_now;
   logic any_trouble;
   logic [15:0] state_flags;
   logic do_write;

   operating_timer #(
      .SECOND_CYCLES(SECOND_CYCLES)
   ) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .seconds(run_seconds)
   );

   // gas_level is in display units; scaling kept in the low 16 bits
   assign conc = 16'(gas_level * MULTIPLIER);
   assign hi_now = conc >= hi_thr_r;
   assign warn_now = conc >= lo_thr_r;
   assign any_trouble = (fault_bits != 16'h0);

   always_comb
   begin
      state_flags = 16'h0;
      state_flags[`ST_RUN_BIT] = !warming && !cal_active && !any_trouble;
      state_flags[`ST_ALARM_BIT] = state_flags[`ST_RUN_BIT] &&
         (hi_latch_r || warn_latch_r);
      state_flags[`ST_WARM_BIT] = warming;
      state_flags[`ST_TROUBLE_BIT] = any_trouble;
      state_flags[`ST_CAL_BIT] = cal_active;
      state_flags[`ST_CAL_PASS_BIT] = cal_active && pass_seen_r;
      state_flags[`ST_CAL_FAIL_BIT] = cal_active && cal_fail;
      // an all-clear word would read as trouble, so force the flag
      if (state_flags == 16'h0)
      begin
         state_flags[`ST_TROUBLE_BIT] = 1'b1;
      end
   end

   function automatic logic [15:0] read_reg(input logic [15:0] a);
      logic [15:0] v;
      v = 16'h0;
      unique case (a)
         `ADDR_CONC: v = conc;
         `ADDR_TEMP: v = temp_tenths;
         `ADDR_HI_RELAY: v = {15'h0, hi_latch_r};
         `ADDR_WARN_RELAY: v = {15'h0, warn_latch_r};
         `ADDR_LO_THR: v = lo_thr_r;
         `ADDR_HI_THR: v = hi_thr_r;
         `ADDR_CFG_DETAIL: v = CFG_DETAIL;
         `ADDR_FW_UPPER: v = FW_UPPER;
         `ADDR_FW_LOWER: v = FW_LOWER;
         `ADDR_MAP_VER: v = MAP_VER;
         `ADDR_FAULT_BITS: v = fault_bits;
         `ADDR_FAULT_SUM: v = {15'h0, any_trouble};
         `ADDR_HI_UNLATCH: v = {15'h0, hi_now};
         `ADDR_WARN_UNLATCH: v = {15'h0, warn_now};
         `ADDR_SERIAL_UP: v = {8'h0, SERIAL_ID[23:16]};
         `ADDR_SERIAL_LO: v = SERIAL_ID[15:0];
         `ADDR_RUN_UP: v = run_seconds[31:16];
         `ADDR_RUN_LO: v = run_seconds[15:0];
         // shared address: peak value wins, product code is unreachable
         `ADDR_PEAK: v = peak_r;
         // shared address: range wins, calibration count is unreachable
         `ADDR_RANGE: v = range_r;
         `ADDR_UNITS: v = units_r;
         `ADDR_STATE: v = state_flags;
         `ADDR_MULT: v = MULTIPLIER;
         `ADDR_CAL_REF: v = cal_ref_r;
         `ADDR_CAL_DUE: v = cal_due_r;
         default: v = 16'h0;
      endcase
      return v;
   endfunction

   always_comb
   begin
      st_nxt = st_r;
      wr_nxt = wr_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      resp_valid_nxt = 1'b0;
      resp_nxt = resp_r;
      do_write = 1'b0;
      unique case (st_r)
         ACC_IDLE:
         begin
            if (req_valid)
            begin
               wr_nxt = req_write;
               addr_nxt = req_addr;
               data_nxt = req_data;
               st_nxt = ACC_DECODE;
            end
         end
         ACC_DECODE:
         begin
            do_write = wr_r;
            st_nxt = ACC_ANSWER;
         end
         ACC_ANSWER:
         begin
            // read after the write landed, so the answer is the new value
            resp_nxt = read_reg(addr_r);
            resp_valid_nxt = 1'b1;
            st_nxt = ACC_IDLE;
         end
      endcase
   end

   always_comb
   begin
      lo_thr_nxt = lo_thr_r;
      hi_thr_nxt = hi_thr_r;
      range_nxt = range_r;
      units_nxt = units_r;
      cal_ref_nxt = cal_ref_r;
      hi_latch_nxt = hi_latch_r;
      warn_latch_nxt = warn_latch_r;
      // only writable registers listed; others ignore writes
      if (do_write)
      begin
         unique case (addr_r)
            `ADDR_LO_THR: lo_thr_nxt = data_r;
            `ADDR_HI_THR: hi_thr_nxt = data_r;
            `ADDR_RANGE: range_nxt = data_r;
            `ADDR_UNITS: units_nxt = data_r;
            `ADDR_CAL_REF: cal_ref_nxt = data_r;
            `ADDR_HI_RELAY:
            begin
               if (data_r == 16'h0)
               begin
                  hi_latch_nxt = 1'b0;
               end
            end
            `ADDR_WARN_RELAY:
            begin
               if (data_r == 16'h0)
               begin
                  warn_latch_nxt = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end
      // a live condition wins over the reset write
      if (hi_now)
      begin
         hi_latch_nxt = 1'b1;
      end
      if (warn_now)
      begin
         warn_latch_nxt = 1'b1;
      end
   end

   always_comb
   begin
      cal_due_nxt = cal_due_r;
      cal_cnt_nxt = cal_cnt_r;
      pass_seen_nxt = cal_active ? (pass_seen_r || cal_pass) : 1'b0;
      peak_nxt = (conc > peak_r) ? conc : peak_r;
      if (cal_pass)
      begin
         cal_due_nxt = LONG_CAL_INTERVAL ? `CAL_DUE_LONG
                                         : `CAL_DUE_SHORT;
         cal_cnt_nxt = cal_cnt_r + 16'h1;
      end
      else if (day_tick)
      begin
         // two's complement: going below zero flags calibration overdue
         cal_due_nxt = cal_due_r - 16'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= ACC_IDLE;
         wr_r <= 1'b0;
         addr_r <= 16'h0;
         data_r <= 16'h0;
         resp_valid_r <= 1'b0;
         resp_r <= 16'h0;
         hi_latch_r <= 1'b0;
         warn_latch_r <= 1'b0;
         lo_thr_r <= `RST_LO_THR;
         hi_thr_r <= `RST_HI_THR;
         range_r <= `RST_RANGE;
         units_r <= `RST_UNITS;
         cal_ref_r <= `RST_CAL_REF;
         cal_due_r <= 16'h0;
         cal_cnt_r <= 16'h0;
         peak_r <= 16'h0;
         pass_seen_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         resp_valid_r <= resp_valid_nxt;
         resp_r <= resp_nxt;
         hi_latch_r <= hi_latch_nxt;
         warn_latch_r <= warn_latch_nxt;
         lo_thr_r <= lo_thr_nxt;
         hi_thr_r <= hi_thr_nxt;
         range_r <= range_nxt;
         units_r <= units_nxt;
         cal_ref_r <= cal_ref_nxt;
         cal_due_r <= cal_due_nxt;
         cal_cnt_r <= cal_cnt_nxt;
         peak_r <= peak_nxt;
         pass_seen_r <= pass_seen_nxt;
      end
   end

   assign resp_valid = resp_valid_r;
   assign resp_data = resp_r;
   assign high_alarm_relay = hi_latch_r;
   assign warning_relay = warn_latch_r;

   sequence take_s;
      st_r == ACC_IDLE && req_valid;
   endsequence

   answer_timing_a: assert property (@(posedge clock) disable iff (!rst_n)
      take_s |-> ##3 resp_valid)
      else $error("answer not three cycles after request");
   write_echo_a: assert property (@(posedge clock) disable iff (!rst_n)
      take_s ##0 (req_write && req_addr == `ADDR_LO_THR) |-> ##3
      resp_data == $past(req_data, 3))
      else $error("write answer not the new setpoint");
   ro_unchanged_a: assert property (@(posedge clock) disable iff (!rst_n)
      take_s ##0 (req_write && req_addr == `ADDR_MULT) |-> ##3
      resp_data == MULTIPLIER)
      else $error("read-only register changed by write");
   alarm_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
      hi_now |=> hi_latch_r)
      else $error("high alarm not latched");
   warn_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
      warn_now |=> warn_latch_r)
      else $error("warning not latched");
   alarm_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      do_write && addr_r == `ADDR_HI_RELAY && data_r == 16'h0 && !hi_now
      |=> !hi_latch_r)
      else $error("alarm reset write ignored");
   status_nonzero_a: assert property (@(posedge clock) disable iff (!rst_n)
      resp_valid_r && addr_r == `ADDR_STATE |-> resp_r != 16'h0)
      else $error("status word reads all clear");
   cal_count_a: assert property (@(posedge clock) disable iff (!rst_n)
      cal_pass |=> cal_cnt_r == $past(cal_cnt_r) + 16'h1)
      else $error("calibration count did not step");
   cal_reload_a: assert property (@(posedge clock) disable iff (!rst_n)
      cal_pass |=> cal_due_r == `CAL_DUE_LONG
      || cal_due_r == `CAL_DUE_SHORT)
      else $error("days due not reloaded");
   trouble_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
      take_s ##0 (!req_write && req_addr == `ADDR_FAULT_SUM) ##1
      (fault_bits != 16'h0) [*2] |=> resp_data == 16'h1)
      else $error("trouble summary wrong");
endmodule

// *** test/host_link_model.sv ***
// host controller model issuing register read and write commands
// assumes the bank takes one request per strobe and answers within a few
// cycles; stimulus changes on the falling edge
module host_link_model
   import sensor_regs_pkg::*;
(
   input wire logic clock,
   output logic req_valid,
   output logic req_write,
   output logic [15:0] req_addr,
   output logic [15:0] req_data,
   input wire logic resp_valid,
   input wire logic [15:0] resp_data
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 16'h0000;
      req_data = 16'h0000;
   end

   // address and data driven together in the same cycle
   task automatic xfer(input logic wr, input word_t addr, input word_t data,
                       output word_t got, output logic ok);
      ok = 1'b0;
      got = 16'h0000;
      @(negedge clock);
      req_valid = 1'b1;
      req_write = wr;
      req_addr = addr;
      req_data = data;
      @(negedge clock);
      req_valid = 1'b0;
      // released lines show garbage, not the last value
      req_write = ~wr;
      req_addr = ~addr;
      req_data = ~data;
      repeat (6)
      begin
         if (resp_valid === 1'b1)
         begin
            ok = 1'b1;
            got = resp_data;
            break;
         end
         @(negedge clock);
      end
   endtask
endmodule

// *** test/sensor_module_register_map_test.sv ***
// self-checking bench for the sensor register bank
// assumes the host model drives requests; live inputs change on falling edge
`include "sensor_regs_consts.svh"
module sensor_module_register_map_test
   import sensor_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clock;
   logic rst_n;
   logic req_valid;
   logic req_write;
   logic [15:0] req_addr;
   logic [15:0] req_data;
   logic resp_valid;
   logic [15:0] resp_data;
   logic [15:0] gas_level;
   logic [15:0] temp_tenths;
   logic [15:0] fault_bits;
   logic warming;
   logic cal_active;
   logic cal_pass;
   logic cal_fail;
   logic day_tick;
   logic high_alarm_relay;
   logic warning_relay;
   int err_count;
   int samples_checked;

   sensor_register_bank #(
      .SERIAL_ID(24'h5a1234), // arbitrary
      .SECOND_CYCLES(10)
   ) DUT (
      .clock(clock), .rst_n(rst_n), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
      .resp_valid(resp_valid), .resp_data(resp_data),
      .gas_level(gas_level), .temp_tenths(temp_tenths),
      .fault_bits(fault_bits), .warming(warming), .cal_active(cal_active),
      .cal_pass(cal_pass), .cal_fail(cal_fail), .day_tick(day_tick),
      .high_alarm_relay(high_alarm_relay), .warning_relay(warning_relay)
   );

   host_link_model host (
      .clock(clock), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_data(req_data),
      .resp_valid(resp_valid), .resp_data(resp_data)
   );

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input word_t got, input word_t exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic access(input logic wr, input word_t addr, input word_t data,
                         input word_t exp);
      word_t got;
      logic ok;
      host.xfer(wr, addr, data, got, ok);
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("[ERR] t=%0t no answer got=%h exp=%h", $time, got, exp);
         test_done();
      end
      check(got, exp);
   endtask

   task automatic rd(input word_t addr, input word_t exp);
      access(1'b0, addr, 16'h0000, exp);
   endtask

   task automatic wr(input word_t addr, input word_t data, input word_t exp);
      access(1'b1, addr, data, exp);
   endtask

   task automatic pulse(ref logic sig);
      @(negedge clock);
      sig = 1'b1;
      @(negedge clock);
      sig = 1'b0;
   endtask

   task automatic reset_values();
      rd(`ADDR_LO_THR, 16'h0014);
      rd(`ADDR_HI_THR, 16'h003c);
      rd(`ADDR_CAL_REF, 16'h0032);
      rd(`ADDR_CAL_DUE, 16'h0000);
      rd(`ADDR_MULT, 16'h000a);
      rd(`ADDR_RANGE, 16'h0064);
      rd(`ADDR_UNITS, 16'h0001);
      rd(16'h9c56, 16'h0000);
      rd(`ADDR_SERIAL_UP, 16'h005a);
      rd(`ADDR_SERIAL_LO, 16'h1234);
      rd(`ADDR_STATE, 16'h0001);
   endtask

   task automatic read_only_writes();
      wr(`ADDR_MULT, 16'h1234, 16'h000a);
      wr(`ADDR_CONC, 16'hffff, 16'h0000);
      wr(`ADDR_FAULT_SUM, 16'h0001, 16'h0000);
      wr(`ADDR_CAL_REF, 16'h0045, 16'h0045);
      rd(`ADDR_CAL_REF, 16'h0045);
      wr(`ADDR_RANGE, 16'h0032, 16'h0032);
      wr(`ADDR_UNITS, 16'h0002, 16'h0002);
      wr(16'h9c56, 16'h00ff, 16'h0000);
   endtask

   task automatic scaling();
      gas_level = 16'h0003;
      temp_tenths = 16'h00fa;
      rd(`ADDR_CONC, 16'h001e);
      rd(`ADDR_TEMP, 16'h00fa);
      gas_level = 16'h0000;
   endtask

   task automatic alarms();
      wr(`ADDR_LO_THR, 16'h000a, 16'h000a);
      wr(`ADDR_HI_THR, 16'h0014, 16'h0014);
      gas_level = 16'h0001;
      rd(`ADDR_WARN_UNLATCH, 16'h0001);
      rd(`ADDR_HI_UNLATCH, 16'h0000);
      gas_level = 16'h0002;
      rd(`ADDR_HI_UNLATCH, 16'h0001);
      check({15'h0000, high_alarm_relay}, 16'h0001);
      check({15'h0000, warning_relay}, 16'h0001);
      rd(`ADDR_STATE, 16'h0003);
      // clear refused while the alarm is still present
      wr(`ADDR_HI_RELAY, 16'h0000, 16'h0001);
      gas_level = 16'h0000;
      rd(`ADDR_HI_UNLATCH, 16'h0000);
      rd(`ADDR_WARN_UNLATCH, 16'h0000);
      rd(`ADDR_HI_RELAY, 16'h0001);
      rd(`ADDR_WARN_RELAY, 16'h0001);
      wr(`ADDR_HI_RELAY, 16'h0000, 16'h0000);
      wr(`ADDR_WARN_RELAY, 16'h0000, 16'h0000);
      check({15'h0000, high_alarm_relay}, 16'h0000);
      check({15'h0000, warning_relay}, 16'h0000);
   endtask

   task automatic trouble();
      fault_bits = 16'h0004;
      rd(`ADDR_FAULT_SUM, 16'h0001);
      rd(`ADDR_FAULT_BITS, 16'h0004);
      rd(`ADDR_STATE, 16'h0008);
      // highest level so far was 3 times the multiplier of 10
      rd(`ADDR_PEAK, 16'h001e);
      fault_bits = 16'h0000;
      rd(`ADDR_FAULT_SUM, 16'h0000);
   endtask

   task automatic calibration();
      warming = 1'b1;
      rd(`ADDR_STATE, 16'h0004);
      warming = 1'b0;
      cal_active = 1'b1;
      rd(`ADDR_STATE, 16'h0010);
      pulse(cal_pass);
      rd(`ADDR_STATE, 16'h0030);
      rd(`ADDR_CAL_DUE, 16'h016d);
      pulse(day_tick);
      rd(`ADDR_CAL_DUE, 16'h016c);
      cal_active = 1'b0;
      rd(`ADDR_STATE, 16'h0001);
      cal_active = 1'b1;
      cal_fail = 1'b1;
      rd(`ADDR_STATE, 16'h0050);
      cal_fail = 1'b0;
      cal_active = 1'b0;
   endtask

   // each access takes four cycles, so ten accesses span four seconds
   task automatic run_time();
      word_t first;
      word_t got;
      logic ok;
      host.xfer(1'b0, `ADDR_RUN_LO, 16'h0000, first, ok);
      repeat (9) rd(`ADDR_RUN_UP, 16'h0000);
      host.xfer(1'b0, `ADDR_RUN_LO, 16'h0000, got, ok);
      check(got - first, 16'h0004);
   endtask

   initial
   begin
      err_count = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      gas_level = 16'h0000;
      temp_tenths = 16'h0000;
      fault_bits = 16'h0000;
      warming = 1'b0;
      cal_active = 1'b0;
      cal_pass = 1'b0;
      cal_fail = 1'b0;
      day_tick = 1'b0;
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      reset_values();
      read_only_writes();
      scaling();
      alarms();
      trouble();
      calibration();
      run_time();
      test_done();
   end
endmodule
